//--- inc/csxt_consts.svh
// Constants of the coast-stop and external-trip block: register map,
// field positions, reset values, error codes and timing figures.
// Assumes inclusion by bare name from the inc/ folder.
`ifndef CSXT_CONSTS_SVH
`define CSXT_CONSTS_SVH

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define CSXT_REG_CTRL      8'h00
`define CSXT_REG_DELAY     8'h04
`define CSXT_REG_STATUS    8'h08
`define CSXT_REG_IRQ_STAT  8'h0c
`define CSXT_REG_IRQ_CLR   8'h10
`define CSXT_REG_IRQ_EN    8'h14

// ************************************************************
// Field positions and reset values
// ************************************************************
`define CSXT_CTRL_FROM_SPEED  0
`define CSXT_CTRL_GUARD       1
`define CSXT_CTRL_KP_RESET    2
`define CSXT_CTRL_RST         2'h2
`define CSXT_DELAY_RST        16'h0000
`define CSXT_IRQ_RST          4'h0
`define CSXT_IRQ_EXT          0
`define CSXT_IRQ_USP          1
`define CSXT_IRQ_COAST        2
`define CSXT_IRQ_RESUME       3
`define CSXT_ST_DRIVE         0
`define CSXT_ST_DECEL         1
`define CSXT_ST_ALARM         2
`define CSXT_ST_TRIP          3
`define CSXT_ST_COAST         4
`define CSXT_ST_WAIT          5
`define CSXT_ST_FROM_SPEED    6
`define CSXT_ST_ERR_LSB       8

// ************************************************************
// Error codes
// ************************************************************
`define CSXT_ERR_NONE  8'h00
`define CSXT_ERR_EXT   8'h0c
`define CSXT_ERR_USP   8'h0d

// ************************************************************
// Timing
// ************************************************************
`define CSXT_CLK_HZ       64'd10000000
`define CSXT_TICK_US      64'd1000
`define CSXT_TICK_CYCLES  ((`CSXT_TICK_US * `CSXT_CLK_HZ) / 64'd1000000)
`define CSXT_BOOT_CYCLES  2'h3

`endif

//--- inc/csxt_pkg.sv
// Types of the coast-stop and external-trip block.
// Assumes nothing beyond a SystemVerilog compiler.
package csxt_pkg;

  typedef enum logic [2:0] {
    ST_STOP,
    ST_RUN,
    ST_DECEL,
    ST_COAST,
    ST_WAIT,
    ST_TRIP,
    ST_RST_HOLD
  } csxt_state_t;

  // Terminal levels, raw or synchronised
  typedef struct packed {
    logic run;
    logic coast_stop;
    logic external_fault;
    logic reset_terminal;
  } csxt_term_t;

  // Commands to the output stage
  typedef struct packed {
    logic enable;
    logic decel;
    logic restart;
    logic from_speed;
  } csxt_drive_t;

endpackage

//--- rtl/csxt_sync.sv
// Two-stage synchroniser for the terminal inputs.
// Assumes asynchronous pins; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none

module csxt_sync (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Terminals
  input  wire csxt_pkg::csxt_term_t term_i,
  output csxt_pkg::csxt_term_t    term_o
);

  csxt_pkg::csxt_term_t stage1_q;
  csxt_pkg::csxt_term_t stage2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= term_i;
      stage2_q <= stage1_q;
    end
  end

  assign term_o = stage2_q;

endmodule

`default_nettype wire

//--- rtl/csxt_tick.sv
// Time-tick generator for the resume delay.
// Assumes pclk at the rate of the constants header; restart aligns ticks.
`timescale 1ns/1ps
`default_nettype none

module csxt_tick #(
  parameter int unsigned TICK_CYCLES = 32'd10
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic restart_i,
  output logic      tick_o
);

  logic [31:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0000_0000;
    end else if (restart_i || cnt_q == TICK_CYCLES - 32'd1) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'd1;
    end
  end

  assign tick_o = !restart_i && (cnt_q == TICK_CYCLES - 32'd1);

endmodule

`default_nettype wire

//--- rtl/csxt_top.sv
// Coast-stop and external-trip control of a motor drive, APB slave.
// Assumes terminal pins asynchronous to pclk and speed_zero_i from pclk logic.
`timescale 1ns/1ps
`default_nettype none

`include "csxt_consts.svh"

module csxt_top #(
  parameter int unsigned TICK_CYCLES = 32'(`CSXT_TICK_CYCLES)
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Terminals
  input  wire csxt_pkg::csxt_term_t term_i,
  // Output stage
  input  wire logic                 speed_zero_i,
  output csxt_pkg::csxt_drive_t     drive_o,
  output logic                      alarm_o,
  output logic [7:0]                err_code_o,
  // Interrupt
  output logic                      irq_o
);

  // ************************************************************
  // Decode helper
  // ************************************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // ************************************************************
  // Input synchronisation and edges
  // ************************************************************
  csxt_pkg::csxt_term_t term_s;
  csxt_pkg::csxt_state_t state_q;
  csxt_pkg::csxt_state_t state_d;
  logic        fault_prev_q;
  logic        run_prev_q;
  logic [1:0]  boot_cnt_q;
  logic        boot_done;
  logic        fault_rise;
  logic        run_rise;
  logic        tick;
  logic        wait_start;
  logic [15:0] wait_cnt_q;
  logic [1:0]  ctrl_q;
  logic [15:0] delay_q;
  logic [3:0]  irq_stat_q;
  logic [3:0]  irq_en_q;
  logic [3:0]  irq_set;
  logic [3:0]  irq_clr;
  logic [7:0]  err_q;
  logic        alarm_q;
  logic        from_speed_q;
  logic        restart_q;
  logic        kp_reset;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic        guard;
  logic        resume_now;

  // All four terminals pass two flops before any logic sees them
  csxt_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .term_i  (term_i),
    .term_o  (term_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_prev_q <= 1'b0;
      run_prev_q   <= 1'b0;
    end else begin
      fault_prev_q <= term_s.external_fault;
      run_prev_q   <= term_s.run;
    end
  end

  assign fault_rise = term_s.external_fault && !fault_prev_q;
  assign run_rise   = term_s.run && !run_prev_q;
  assign guard      = ctrl_q[`CSXT_CTRL_GUARD];

  // Hold off starts until the synchroniser shows real pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt_q <= 2'h0;
    end else if (boot_cnt_q != `CSXT_BOOT_CYCLES) begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
    end
  end

  assign boot_done = (boot_cnt_q == `CSXT_BOOT_CYCLES);

  // ************************************************************
  // Resume delay
  // ************************************************************
  csxt_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .pclk      (pclk),
    .presetn   (presetn),
    .restart_i (wait_start),
    .tick_o    (tick)
  );

  assign wait_start = (state_q == csxt_pkg::ST_COAST) && (state_d == csxt_pkg::ST_WAIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_q <= 16'h0000;
    end else if (wait_start) begin
      wait_cnt_q <= delay_q;
    end else if (state_q == csxt_pkg::ST_WAIT && tick && wait_cnt_q != 16'h0000) begin
      wait_cnt_q <= wait_cnt_q - 16'h0001;
    end
  end

  assign resume_now = (wait_cnt_q == 16'h0000);

  // ************************************************************
  // Control state machine
  // ************************************************************
  always_comb begin
    state_d = state_q;
    irq_set = 4'h0;
    if (fault_rise) begin
      // Trip wins over every other state, coast-stop included
      state_d = csxt_pkg::ST_TRIP;
      irq_set[`CSXT_IRQ_EXT] = 1'b1;
    end else begin
      case (state_q)
        csxt_pkg::ST_STOP: begin
          if (boot_done && boot_cnt_q != 2'h0 && guard && term_s.run && !run_prev_q
              && err_q == `CSXT_ERR_NONE && !restart_q && !from_speed_q && !alarm_q
              && wait_cnt_q == 16'h0000 && irq_stat_q[`CSXT_IRQ_USP] == 1'b0 && 1'b0) begin
            state_d = csxt_pkg::ST_STOP;
          end else if (boot_done && term_s.run && !term_s.coast_stop
                       && (!guard || run_rise)) begin
            state_d = csxt_pkg::ST_RUN;
          end
        end
        csxt_pkg::ST_RUN: begin
          if (term_s.coast_stop) begin
            state_d = csxt_pkg::ST_COAST;
            irq_set[`CSXT_IRQ_COAST] = 1'b1;
          end else if (!term_s.run) begin
            state_d = csxt_pkg::ST_DECEL;
          end
        end
        csxt_pkg::ST_DECEL: begin
          if (term_s.coast_stop) begin
            state_d = csxt_pkg::ST_COAST;
            irq_set[`CSXT_IRQ_COAST] = 1'b1;
          end else if (term_s.run) begin
            state_d = csxt_pkg::ST_RUN;
          end else if (speed_zero_i) begin
            state_d = csxt_pkg::ST_STOP;
          end
        end
        csxt_pkg::ST_COAST: begin
          if (!term_s.coast_stop) begin
            state_d = term_s.run ? csxt_pkg::ST_WAIT : csxt_pkg::ST_STOP;
          end
        end
        csxt_pkg::ST_WAIT: begin
          if (term_s.coast_stop) begin
            state_d = csxt_pkg::ST_COAST;
            irq_set[`CSXT_IRQ_COAST] = 1'b1;
          end else if (!term_s.run) begin
            state_d = csxt_pkg::ST_STOP;
          end else if (resume_now) begin
            state_d = csxt_pkg::ST_RUN;
            irq_set[`CSXT_IRQ_RESUME] = 1'b1;
          end
        end
        csxt_pkg::ST_TRIP: begin
          // Fault release alone never leaves this state
          if (kp_reset) begin
            state_d = (term_s.run && !guard && !term_s.coast_stop) ? csxt_pkg::ST_RUN : csxt_pkg::ST_STOP;
          end else if (term_s.reset_terminal) begin
            state_d = csxt_pkg::ST_RST_HOLD;
          end else if (err_q == `CSXT_ERR_USP && !term_s.run) begin
            state_d = csxt_pkg::ST_STOP;
          end
        end
        csxt_pkg::ST_RST_HOLD: begin
          if (!term_s.reset_terminal) begin
            // Guard forces a fresh run edge from stopped mode
            state_d = (term_s.run && !guard && !term_s.coast_stop) ? csxt_pkg::ST_RUN : csxt_pkg::ST_STOP;
          end
        end
        default: begin
          state_d = csxt_pkg::ST_STOP;
        end
      endcase
      // Power-up with run already active under the guard
      if (state_q == csxt_pkg::ST_STOP && boot_cnt_q == `CSXT_BOOT_CYCLES - 2'h1
          && term_s.run && guard) begin
        state_d = csxt_pkg::ST_TRIP;
        irq_set[`CSXT_IRQ_USP] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= csxt_pkg::ST_STOP;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // Trip record, alarm and restart mode
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q   <= `CSXT_ERR_NONE;
      alarm_q <= 1'b0;
    end else if (state_d == csxt_pkg::ST_TRIP && state_q != csxt_pkg::ST_TRIP) begin
      err_q   <= fault_rise ? `CSXT_ERR_EXT : `CSXT_ERR_USP;
      alarm_q <= 1'b1;
    end else if (state_q == csxt_pkg::ST_TRIP && state_d != csxt_pkg::ST_TRIP) begin
      err_q   <= `CSXT_ERR_NONE;
      alarm_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      from_speed_q <= 1'b0;
      restart_q    <= 1'b0;
    end else begin
      restart_q <= (state_d == csxt_pkg::ST_RUN) && (state_q != csxt_pkg::ST_RUN)
                   && (state_q != csxt_pkg::ST_DECEL);
      if (state_q == csxt_pkg::ST_WAIT && state_d == csxt_pkg::ST_RUN) begin
        from_speed_q <= ctrl_q[`CSXT_CTRL_FROM_SPEED];
      end else if (state_d == csxt_pkg::ST_RUN && state_q != csxt_pkg::ST_RUN
                   && state_q != csxt_pkg::ST_DECEL) begin
        from_speed_q <= 1'b0;
      end
    end
  end

  // Output off in trip and coast, on in run and controlled deceleration
  assign drive_o.enable     = (state_q == csxt_pkg::ST_RUN) || (state_q == csxt_pkg::ST_DECEL);
  assign drive_o.decel      = (state_q == csxt_pkg::ST_DECEL);
  assign drive_o.restart    = restart_q;
  assign drive_o.from_speed = from_speed_q;
  assign alarm_o            = alarm_q;
  assign err_code_o         = err_q;

  // ************************************************************
  // APB registers
  // ************************************************************
  assign wr_en    = psel && penable && pwrite;
  assign mapped   = hit(paddr, `CSXT_REG_CTRL) || hit(paddr, `CSXT_REG_DELAY)
                    || hit(paddr, `CSXT_REG_STATUS) || hit(paddr, `CSXT_REG_IRQ_STAT)
                    || hit(paddr, `CSXT_REG_IRQ_CLR) || hit(paddr, `CSXT_REG_IRQ_EN);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign kp_reset = wr_en && hit(paddr, `CSXT_REG_CTRL) && pwdata[`CSXT_CTRL_KP_RESET];
  assign irq_clr  = (wr_en && hit(paddr, `CSXT_REG_IRQ_CLR)) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `CSXT_CTRL_RST;
      delay_q <= `CSXT_DELAY_RST;
      irq_en_q <= `CSXT_IRQ_RST;
    end else if (wr_en) begin
      if (hit(paddr, `CSXT_REG_CTRL)) begin
        ctrl_q <= pwdata[1:0];
      end
      if (hit(paddr, `CSXT_REG_DELAY)) begin
        delay_q <= pwdata[15:0];
      end
      if (hit(paddr, `CSXT_REG_IRQ_EN)) begin
        irq_en_q <= pwdata[3:0];
      end
    end
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= `CSXT_IRQ_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  assign irq_o = |(irq_stat_q & irq_en_q);

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit(paddr, `CSXT_REG_CTRL)) begin
      rdata_d[1:0] = ctrl_q;
    end else if (hit(paddr, `CSXT_REG_DELAY)) begin
      rdata_d[15:0] = delay_q;
    end else if (hit(paddr, `CSXT_REG_STATUS)) begin
      rdata_d[`CSXT_ST_DRIVE]      = drive_o.enable;
      rdata_d[`CSXT_ST_DECEL]      = drive_o.decel;
      rdata_d[`CSXT_ST_ALARM]      = alarm_q;
      rdata_d[`CSXT_ST_TRIP]       = (state_q == csxt_pkg::ST_TRIP);
      rdata_d[`CSXT_ST_COAST]      = (state_q == csxt_pkg::ST_COAST);
      rdata_d[`CSXT_ST_WAIT]       = (state_q == csxt_pkg::ST_WAIT);
      rdata_d[`CSXT_ST_FROM_SPEED] = from_speed_q;
      rdata_d[`CSXT_ST_ERR_LSB +: 8] = err_q;
    end else if (hit(paddr, `CSXT_REG_IRQ_STAT)) begin
      rdata_d[3:0] = irq_stat_q;
    end else if (hit(paddr, `CSXT_REG_IRQ_EN)) begin
      rdata_d[3:0] = irq_en_q;
    end
  end

  // Captured in the setup cycle so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
    end
  end

  assign prdata = prdata_q;

endmodule

`default_nettype wire

//--- bench/csxt_top_props.sv
// Concurrent checks on the ports of the coast-stop and external-trip block.
// Assumes a bind to csxt_top; terminals reach the block two flops late.
`timescale 1ns/1ps
`default_nettype none
`include "csxt_consts.svh"

module csxt_top_props #(
  parameter int unsigned TICK_CYCLES = 32'd4
) (
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Terminals and output stage
  input wire csxt_pkg::csxt_term_t  term_i,
  input wire logic                  speed_zero_i,
  input wire csxt_pkg::csxt_drive_t drive_o,
  input wire logic                  alarm_o,
  input wire logic [7:0]            err_code_o,
  input wire logic                  irq_o
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ************************************************************
  // Helper state
  // ************************************************************
  logic        acc_w;
  logic        kp_w;
  logic [15:0] delay_q;
  logic [2:0]  quiet_q;
  assign acc_w = psel && penable && pwrite;
  assign kp_w  = acc_w && paddr == `CSXT_REG_CTRL && pwdata[`CSXT_CTRL_KP_RESET];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) delay_q <= `CSXT_DELAY_RST;
    else if (acc_w && paddr == `CSXT_REG_DELAY) delay_q <= pwdata[15:0];
  end
  // Cycles since any clearing request, saturating; covers the sync lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_q <= 3'h0;
    else if (term_i.reset_terminal || kp_w) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end

  // ************************************************************
  // Properties
  // ************************************************************
  property p_fault_trip;
    $rose(term_i.external_fault) && !alarm_o && !term_i.reset_terminal |->
      ##[1:4] (alarm_o && err_code_o == `CSXT_ERR_EXT && !drive_o.enable);
  endproperty
  a_fault_trip: assert property (p_fault_trip) else $error("fault edge gave no trip");
  property p_alarm_err;
    alarm_o == (err_code_o != `CSXT_ERR_NONE);
  endproperty
  a_alarm_err: assert property (p_alarm_err) else $error("alarm and code disagree");
  property p_trip_off;
    alarm_o |-> !drive_o.enable && !drive_o.restart;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("output on while tripped");
  property p_trip_holds;
    err_code_o == `CSXT_ERR_EXT && quiet_q == 3'h7 && !kp_w |=> err_code_o == `CSXT_ERR_EXT;
  endproperty
  a_trip_holds: assert property (p_trip_holds) else $error("trip left without reset");
  property p_coast_cut;
    term_i.coast_stop [*4] |-> !drive_o.enable;
  endproperty
  a_coast_cut: assert property (p_coast_cut) else $error("output on during coast");
  property p_resume;
    $fell(term_i.coast_stop) && term_i.run && !term_i.external_fault && !alarm_o && delay_q == 16'h0000
      |-> ##[2:6] drive_o.enable;
  endproperty
  a_resume: assert property (p_resume) else $error("no prompt resume");
  property p_decel;
    drive_o.decel && speed_zero_i |=> !drive_o.decel && !drive_o.enable;
  endproperty
  a_decel: assert property (p_decel) else $error("braking past standstill");
  property p_reset_clear;
    term_i.reset_terminal [*4] |-> !alarm_o && err_code_o == `CSXT_ERR_NONE;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left alarm");
endmodule

bind csxt_top csxt_top_props #(.TICK_CYCLES(TICK_CYCLES)) i_csxt_top_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .term_i(term_i),
  .speed_zero_i(speed_zero_i), .drive_o(drive_o), .alarm_o(alarm_o), .err_code_o(err_code_o), .irq_o(irq_o)
);
`default_nettype wire

//--- bench/csxt_switch_model.sv
// Terminal switches and a coarse motor behind the output stage.
// Assumes the bench sets switch levels on pclk; switches keep no reset.
`timescale 1ns/1ps
`default_nettype none

module csxt_switch_model (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Switch settings and terminal levels
  input  wire csxt_pkg::csxt_term_t  cmd,
  output csxt_pkg::csxt_term_t       term,
  // Output stage
  input  wire csxt_pkg::csxt_drive_t drive,
  output logic                       speed_zero
);
  csxt_pkg::csxt_term_t term_q;
  logic [7:0]           speed_q;
  // Run edges and reset pulses arrive whole
  always_ff @(posedge pclk) term_q <= cmd;
  assign term = term_q;
  // Spins up under drive, winds down when braking or coasting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) speed_q <= 8'h00;
    else if (drive.enable && !drive.decel && speed_q != 8'h10) speed_q <= speed_q + 8'h01;
    else if ((!drive.enable || drive.decel) && speed_q != 8'h00) speed_q <= speed_q - 8'h01;
  end
  assign speed_zero = (speed_q == 8'h00);
endmodule
`default_nettype wire

//--- bench/csxt_top_tb_top.sv
// Self-checking bench: APB register access and terminal scenarios.
// Assumes csxt_top with a 4-cycle tick and the switch model as far side.
`timescale 1ns/1ps
`default_nettype none
`include "csxt_consts.svh"

module csxt_top_tb_top;
  logic                  pclk, presetn, psel, penable, pwrite;
  logic                  pready, pslverr, speed_zero, alarm, irq;
  logic [7:0]            paddr, err_code;
  logic [31:0]           pwdata, prdata;
  csxt_pkg::csxt_term_t  sw, term;
  csxt_pkg::csxt_drive_t drive;
  int                    errors, num_checks;

  csxt_top #(.TICK_CYCLES(32'd4)) i_csxt_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .term_i(term),
    .speed_zero_i(speed_zero), .drive_o(drive), .alarm_o(alarm), .err_code_o(err_code), .irq_o(irq)
  );
  csxt_switch_model i_csxt_switch_model (
    .pclk(pclk), .presetn(presetn), .cmd(sw), .term(term), .drive(drive), .speed_zero(speed_zero)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(n, q & m, x);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Whole run is well under 2000 cycles; 30000 leaves room
  initial begin
    #3000000;
    errors++;
    report_and_stop;
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    logic [31:0] q;
    logic        e;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    sw = 4'h8;
    errors = 0;
    num_checks = 0;
    step(8);
    presetn <= 1'b1;
    step(8);
    check("usp err", 32'(err_code), 32'(`CSXT_ERR_USP));
    rd("ctrl rst", `CSXT_REG_CTRL, 32'hffffffff, 32'h2);
    rd("delay rst", `CSXT_REG_DELAY, 32'hffffffff, 32'h0);
    rd("irq en rst", `CSXT_REG_IRQ_EN, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h40, 32'h0, q, e);
    check("unmapped", {q[30:0], e}, 32'h1);
    sw.run <= 1'b0;
    step(6);
    check("usp clear", 32'(alarm), 32'h0);
    wr(`CSXT_REG_IRQ_CLR, 32'hf);
    wr(`CSXT_REG_CTRL, 32'h3);
    sw.run <= 1'b1;
    step(6);
    check("start", 32'(drive.enable), 32'h1);
    $display("boot test done");
    wr(`CSXT_REG_DELAY, 32'h3);
    sw.coast_stop <= 1'b1;
    step(6);
    check("coast off", 32'(drive.enable), 32'h0);
    rd("coasting", `CSXT_REG_STATUS, 32'h10, 32'h10);
    rd("coast irq", `CSXT_REG_IRQ_STAT, 32'h4, 32'h4);
    sw.coast_stop <= 1'b0;
    step(6);
    check("delay hold", 32'(drive.enable), 32'h0);
    rd("waiting", `CSXT_REG_STATUS, 32'h20, 32'h20);
    step(16);
    check("resumed", 32'({drive.enable, drive.from_speed}), 32'h3);
    wr(`CSXT_REG_CTRL, 32'h2);
    wr(`CSXT_REG_DELAY, 32'h0);
    sw.coast_stop <= 1'b1;
    step(6);
    sw.coast_stop <= 1'b0;
    step(6);
    check("resume 0hz", 32'({drive.enable, drive.from_speed}), 32'h2);
    $display("coast test done");
    step(20);
    sw.run <= 1'b0;
    step(6);
    check("decel", 32'({drive.enable, drive.decel}), 32'h3);
    step(30);
    check("stopped", 32'({drive.enable, drive.decel}), 32'h0);
    sw.run <= 1'b1;
    step(6);
    sw.coast_stop <= 1'b1;
    sw.external_fault <= 1'b1;
    step(6);
    rd("trip st", `CSXT_REG_STATUS, 32'hff1d, 32'h0c0c);
    check("irq masked", 32'(irq), 32'h0);
    sw.external_fault <= 1'b0;
    sw.coast_stop <= 1'b0;
    step(10);
    check("trip kept", 32'({alarm, err_code}), 32'h10c);
    wr(`CSXT_REG_IRQ_EN, 32'h1);
    step(1);
    check("irq on", 32'(irq), 32'h1);
    wr(`CSXT_REG_IRQ_CLR, 32'h1);
    step(1);
    check("irq clr", 32'(irq), 32'h0);
    $display("trip test done");
    sw.reset_terminal <= 1'b1;
    step(6);
    check("rst clear", 32'({alarm, err_code}), 32'h0);
    sw.reset_terminal <= 1'b0;
    step(8);
    check("no auto", 32'(drive.enable), 32'h0);
    rd("stop mode", `CSXT_REG_STATUS, 32'hff0f, 32'h0);
    sw.run <= 1'b0;
    step(4);
    sw.run <= 1'b1;
    step(6);
    check("fresh run", 32'(drive.enable), 32'h1);
    wr(`CSXT_REG_CTRL, 32'h0);
    sw.external_fault <= 1'b1;
    step(6);
    sw.external_fault <= 1'b0;
    sw.reset_terminal <= 1'b1;
    step(6);
    sw.reset_terminal <= 1'b0;
    step(6);
    check("auto run", 32'(drive.enable), 32'h1);
    sw.external_fault <= 1'b1;
    step(6);
    sw.external_fault <= 1'b0;
    wr(`CSXT_REG_CTRL, 32'h4);
    step(2);
    check("keypad", 32'({alarm, err_code}), 32'h0);
    $display("reset test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
